// [design/sbs_port_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module sbs_port_ctrl #(
  parameter int ADDR_W = sbs_pkg::ADDR_W,
  parameter int LANES  = sbs_pkg::LANES,
  parameter int LANE_W = sbs_pkg::LANE_W
) (
  // clock and reset
  input  wire logic                      i_clk,
  input  wire logic                      i_sys_rst,
  // address and strobes
  input  wire logic [ADDR_W-1:0]         i_addr,
  input  wire logic                      i_chip_sel_a_n,
  input  wire logic                      i_chip_sel_b,
  input  wire logic                      i_chip_sel_c_n,
  input  wire logic                      i_cpu_addr_strobe_n,
  input  wire logic                      i_ctrl_addr_strobe_n,
  input  wire logic                      i_burst_advance_n,
  // writes
  input  wire logic                      i_lane_write_en_n,
  input  wire logic [LANES-1:0]          i_lane_write_sel_n,
  input  wire logic                      i_all_lane_write_n,
  // async controls and strap
  input  wire logic                      i_out_en_n,
  input  wire logic                      i_sleep_req,
  input  wire logic                      i_burst_order,
  // data and parity pins
  input  wire logic [LANES*LANE_W-1:0]   i_data,
  output logic      [LANES*LANE_W-1:0]   o_data,
  output logic      [LANES*LANE_W-1:0]   o_data_oe,
  input  wire logic [LANES-1:0]          i_parity_io,
  output logic      [LANES-1:0]          o_parity_io,
  output logic      [LANES-1:0]          o_parity_io_oe
);
  localparam int CW = sbs_pkg::CNT_W;
  localparam int LW = LANE_W + 1;
  // the burst counter needs address bits above it, and at least one lane
  if (ADDR_W <= CW || LANES < 1 || LANE_W < 1) begin : g_bad_params
    $error("sbs_port_ctrl: bad parameters");
  end

  typedef enum logic [2:0] {
    SBS_DESEL = 3'h1,
    SBS_FIRST = 3'h2,
    SBS_ACTIVE = 3'h4
  } sbs_state_e;

  sbs_state_e           st_q, st_d;
  logic [ADDR_W-1:0]    base_q, base_d;
  logic [CW-1:0]        cnt_q, cnt_d;
  logic                 wphase_q, wphase_d;
  logic                 order_q, order_d;
  logic                 strap_done_q, strap_done_d;
  logic                 cpu_load, ctrl_load, load, sel_now, write_now;
  logic [LANES-1:0]     lane_wr;
  logic [CW-1:0]        low_addr;
  logic [ADDR_W-1:0]    cur_addr;

  sbs_mem_if #(.AW(ADDR_W), .DW(LANES*LW), .NL(LANES)) mif ();

  // strobe decode; cpu strobe ignored while sel_a high
  always_comb begin
    cpu_load  = !i_cpu_addr_strobe_n && !i_chip_sel_a_n;
    ctrl_load = !i_ctrl_addr_strobe_n && !cpu_load;
    load      = (cpu_load || ctrl_load) && !i_sleep_req;
    sel_now   = !i_chip_sel_a_n && i_chip_sel_b && !i_chip_sel_c_n;
  end

  // write qualification; cpu-strobe cycle ignores write inputs
  always_comb begin
    for (int l = 0; l < LANES; l++) begin
      lane_wr[l] = !i_all_lane_write_n || (!i_lane_write_en_n && !i_lane_write_sel_n[l]);
    end
    write_now = (|lane_wr) && !i_sleep_req && !cpu_load
                && (st_q != SBS_DESEL || (load && sel_now));
  end

  // burst address; interleave xors start bits with the count
  // built from next values: an advance must fetch the stepped word at that edge
  always_comb begin
    low_addr = (order_q == sbs_pkg::ORDER_LINEAR) ? base_d[CW-1:0] + cnt_d
                                                  : base_d[CW-1:0] ^ cnt_d;
    cur_addr = {base_d[ADDR_W-1:CW], low_addr};
  end

  // next state: selects looked at only when an address loads
  always_comb begin
    st_d         = st_q;
    base_d       = base_q;
    cnt_d        = cnt_q;
    wphase_d     = 1'b0;
    order_d      = order_q;
    strap_done_d = 1'b1;
    if (!strap_done_q) begin
      order_d = i_burst_order;
    end
    if (load) begin
      base_d = i_addr;
      cnt_d  = sbs_pkg::CNT_ZERO;
      if (sel_now) begin
        st_d = (st_q == SBS_DESEL) ? SBS_FIRST : SBS_ACTIVE;
      end else begin
        st_d = SBS_DESEL;
      end
    end else begin
      if (st_q == SBS_FIRST) begin
        st_d = SBS_ACTIVE;
      end
      if (st_q != SBS_DESEL && !i_burst_advance_n && !i_sleep_req) begin
        cnt_d = cnt_q + sbs_pkg::CNT_ONE;
      end
    end
    if (write_now) begin
      wphase_d = 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_q         <= SBS_DESEL;
      base_q       <= '0;
      cnt_q        <= sbs_pkg::CNT_ZERO;
      wphase_q     <= 1'b0;
      order_q      <= 1'b1;
      strap_done_q <= 1'b0;
    end else begin
      st_q         <= st_d;
      base_q       <= base_d;
      cnt_q        <= cnt_d;
      wphase_q     <= wphase_d;
      order_q      <= order_d;
      strap_done_q <= strap_done_d;
    end
  end

  // core access: write data taken from pins at the edge
  always_comb begin
    mif.addr = load ? i_addr : cur_addr;
    for (int l = 0; l < LANES; l++) begin
      mif.wr_lane[l] = write_now && lane_wr[l] && !load;
      mif.wdata[l*LW +: LW] = {i_parity_io[l], i_data[l*LANE_W +: LANE_W]};
    end
    if (load) begin
      for (int l = 0; l < LANES; l++) begin
        mif.wr_lane[l] = 1'b0;
      end
    end
  end

  sbs_mem #(.AW(ADDR_W), .NL(LANES), .LW(LW)) u_mem (
    .i_clk (i_clk),
    .m     (mif.mem)
  );

  // read data is from the address of the previous edge
  logic drive;
  always_comb begin
    drive = !i_out_en_n && (st_q == SBS_ACTIVE) && !wphase_q;
    for (int l = 0; l < LANES; l++) begin
      o_data[l*LANE_W +: LANE_W] = mif.rdata[l*LW +: LANE_W];
      o_parity_io[l] = mif.rdata[l*LW + LANE_W];
    end
    o_data_oe      = {(LANES*LANE_W){drive}};
    o_parity_io_oe = {LANES{drive}};
  end

  AST_DESEL_TRI: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (st_q == SBS_DESEL) |-> o_data_oe == '0) else $error("drive while deselected");
  AST_FIRST_TRI: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (st_q == SBS_FIRST) |-> o_data_oe == '0) else $error("drive on first clock");
  AST_WRITE_TRI: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    write_now |=> o_data_oe == '0) else $error("drive in write phase");
  AST_SELECT: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (load && !sel_now) |=> st_q == SBS_DESEL) else $error("select decode");
  AST_HOLD_SEL: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (!load && st_q == SBS_ACTIVE) |=> st_q == SBS_ACTIVE) else $error("select changed");
  AST_CPU_IGN: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_chip_sel_a_n && i_ctrl_addr_strobe_n) |-> !load) else $error("cpu strobe used");
  AST_LOAD: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    load |=> base_q == $past(i_addr) && cnt_q == '0) else $error("address not loaded");
  AST_ADV: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (!load && i_burst_advance_n) |=> cnt_q == $past(cnt_q)) else $error("counter moved");
  AST_STEP: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (!load && !i_burst_advance_n && !i_sleep_req && st_q != SBS_DESEL)
    |=> cnt_q == $past(cnt_q) + sbs_pkg::CNT_ONE) else $error("counter stuck");
  AST_OE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_out_en_n |-> o_data_oe == '0) else $error("drive with oe high");

  // selected load out of deselect, then one quiet clock
  sequence s_fresh_sel;
    st_q == SBS_DESEL && load && sel_now;
  endsequence
  sequence s_quiet;
    !load && !write_now;
  endsequence
  // mask lasts exactly one clock, then output enable rules again
  AST_FIRST_MASK: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    s_fresh_sel ##1 s_quiet |=> (i_out_en_n || o_data_oe == '1)) else $error("mask too long");
  AST_FIRST_ONE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (st_q == SBS_FIRST && !load) |=> st_q == SBS_ACTIVE) else $error("first clock stuck");

  // strobe race: cpu strobe wins, so its write inputs open no write phase
  AST_CPU_WINS: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (!i_cpu_addr_strobe_n && !i_chip_sel_a_n && !i_ctrl_addr_strobe_n && !i_sleep_req)
    |=> !wphase_q) else $error("controller strobe taken");
  AST_DESEL_HOLD: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (!load && st_q == SBS_DESEL) |=> st_q == SBS_DESEL) else $error("left deselect");

  // sleep freezes address and counter
  AST_SLEEP: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_sleep_req |=> base_q == $past(base_q) && cnt_q == $past(cnt_q))
    else $error("moved in sleep");
  AST_STRAP: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    strap_done_q |=> order_q == $past(order_q)) else $error("strap changed");

  // global write opens every lane; a lane select only opens its own lane
  AST_ALL_LANES: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (write_now && !load && !i_all_lane_write_n) |-> &mif.wr_lane) else $error("lane missed");
  for (genvar g = 0; g < LANES; g++) begin : g_lane_chk
    AST_LANE_OWN: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_all_lane_write_n && i_lane_write_sel_n[g]) |-> !mif.wr_lane[g])
      else $error("unselected lane written");
  end
endmodule
`default_nettype wire

// [design/sbs_pkg.sv]
package sbs_pkg;
  localparam int ADDR_W   = 19;
  localparam int LANES    = 4;
  localparam int LANE_W   = 8;
  localparam int CNT_W    = 2;
  localparam logic [CNT_W-1:0] CNT_ONE = 2'h1;
  localparam logic [CNT_W-1:0] CNT_ZERO = 2'h0;
  localparam logic ORDER_LINEAR = 1'b0;
endpackage

// [design/sbs_mem_if.sv]
`timescale 1ns/1ps
`default_nettype none
// core array port: one write and one registered read per clock
interface sbs_mem_if #(parameter int AW = 19, parameter int DW = 36, parameter int NL = 4);
  logic [AW-1:0] addr;
  logic [NL-1:0] wr_lane;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  modport ctrl (output addr, output wr_lane, output wdata, input rdata);
  modport mem  (input addr, input wr_lane, input wdata, output rdata);
endinterface
`default_nettype wire

// [design/sbs_mem.sv]
`timescale 1ns/1ps
`default_nettype none
module sbs_mem #(
  parameter int AW = 19,
  parameter int NL = 4,
  parameter int LW = 9
) (
  input  wire logic i_clk,
  sbs_mem_if.mem    m
);
  // one array per lane, so no two processes ever write the same variable
  // lane carries data bits plus its parity bit; stored contents never reset
  for (genvar g = 0; g < NL; g++) begin : g_lane
    logic [LW-1:0] arr_q [2**AW];
    logic [LW-1:0] rd_q;
    // lane write and registered read of the same address
    always_ff @(posedge i_clk) begin
      if (m.wr_lane[g]) begin
        arr_q[m.addr] <= m.wdata[g*LW +: LW];
      end
      rd_q <= arr_q[m.addr];
    end
    assign m.rdata[g*LW +: LW] = rd_q;
  end
endmodule
`default_nettype wire

// [verification/sbs_host_bus.sv]
`timescale 1ns/1ps
`default_nettype none
module sbs_host_bus (
  // clock
  input  wire logic        i_clk,
  // host and device drivers
  input  wire logic        i_host_oe,
  input  wire logic [35:0] i_host_d,
  input  wire logic [35:0] i_dev_d,
  input  wire logic [35:0] i_dev_oe,
  // resolved pin level
  output logic      [35:0] o_wire
);
  logic [35:0] last_q = '0;
  // undriven bits flip away from their last level so stale data never passes
  always_comb begin
    for (int b = 0; b < 36; b++) begin
      o_wire[b] = i_dev_oe[b] ? i_dev_d[b] : (i_host_oe ? i_host_d[b] : ~last_q[b]);
    end
  end
  // history for the floating case
  always_ff @(posedge i_clk) last_q <= o_wire;
endmodule
`default_nettype wire

// [verification/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        i_clk = 0, i_sys_rst = 1, host_oe = 0;
  logic [18:0] addr = '0;
  logic        sa_n = 1, sb = 0, sc_n = 1, cpu_n = 1, ctl_n = 1, adv_n = 1;
  logic        we_n = 1, all_n = 1, oe_n = 0, slp = 0;
  logic        mode = 0;
  logic [3:0]  sel_n = 4'hf;
  logic [35:0] host_d = '0;
  logic [35:0] mem [0:7];
  wire logic [31:0] rd_d, rd_oe;
  wire logic [3:0]  rp, rp_oe;
  wire logic [35:0] pin;
  int n_errors = 0, total_checks = 0;
  // free running 50 MHz clock
  always #10 i_clk = ~i_clk;
  sbs_port_ctrl dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(addr),
    .i_chip_sel_a_n(sa_n), .i_chip_sel_b(sb), .i_chip_sel_c_n(sc_n),
    .i_cpu_addr_strobe_n(cpu_n), .i_ctrl_addr_strobe_n(ctl_n), .i_burst_advance_n(adv_n),
    .i_lane_write_en_n(we_n), .i_lane_write_sel_n(sel_n), .i_all_lane_write_n(all_n),
    .i_out_en_n(oe_n), .i_sleep_req(slp), .i_burst_order(mode), .i_data(pin[31:0]),
    .o_data(rd_d), .o_data_oe(rd_oe), .i_parity_io(pin[35:32]), .o_parity_io(rp),
    .o_parity_io_oe(rp_oe));
  sbs_host_bus host (.i_clk(i_clk), .i_host_oe(host_oe), .i_host_d(host_d),
    .i_dev_d({rp, rd_d}), .i_dev_oe({rp_oe, rd_oe}), .o_wire(pin));
  task automatic chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic step();
    @(posedge i_clk);
    #1;
  endtask
  // expected burst index: linear adds the count, interleave xors it
  function automatic logic [2:0] nxt(input logic [2:0] a, input logic [1:0] k);
    return mode ? {a[2], a[1:0] ^ k} : {a[2], a[1:0] + k};
  endfunction
  // one address load; sel is {a_n, b, c_n}
  task automatic load(input logic [18:0] a, input logic cpu, input logic [2:0] sel);
    addr = a;
    {sa_n, sb, sc_n} = sel;
    cpu_n = !cpu;
    ctl_n = cpu;
    step();
    cpu_n = 1;
    ctl_n = 1;
  endtask
  // controller load then one write beat; host drives only with outputs off
  task automatic wr(input logic [2:0] a, input logic [35:0] d, input logic [3:0] ln_n,
                    input logic all, input logic zz);
    slp = zz;
    load({16'h0, a}, 0, 3'b010);
    oe_n = 1;
    host_oe = 1;
    host_d = d;
    we_n = 0;
    sel_n = ln_n;
    all_n = !all;
    step();
    {host_oe, we_n, sel_n, all_n, slp, oe_n} = {1'b0, 1'b1, 4'hf, 1'b1, 1'b0, 1'b0};
    #1;
    if (!zz) chk("oe after write", {rp_oe, rd_oe}, '0);
    for (int l = 0; l < 4; l++) begin
      if (!zz && (all || !ln_n[l])) begin
        mem[a][8*l +: 8] = d[8*l +: 8];
        mem[a][32+l] = d[32+l];
      end
    end
  endtask
  // deselect, load, then one advance
  task automatic rd(input logic [2:0] a, input logic cpu);
    oe_n = 0;
    load('0, 0, 3'b000);
    chk("oe deselected", {rp_oe, rd_oe}, '0);
    load({16'h0, a}, cpu, 3'b010);
    chk("oe first clock", {rp_oe, rd_oe}, '0);
    chk("data first", {rp, rd_d}, mem[a]);
    adv_n = 0;
    step();
    adv_n = 1;
    chk("oe active", {rp_oe, rd_oe}, '1);
    chk("data next", {rp, rd_d}, mem[nxt(a, 2'h1)]);
    oe_n = 1;
    #1;
    chk("oe released", {rp_oe, rd_oe}, '0);
  endtask
  // cpu strobe with sel_a high mid burst must not disturb the burst
  task automatic burst_keep(input logic [2:0] a);
    rd(a, 1);
    oe_n = 0;
    {sa_n, sb, sc_n, cpu_n, adv_n} = 5'b10000;
    step();
    {cpu_n, adv_n} = 2'b11;
    chk("oe ignored strobe", {rp_oe, rd_oe}, '1);
    chk("data third", {rp, rd_d}, mem[nxt(a, 2'h2)]);
  endtask
  // both strobes low with global write low: cpu strobe wins, so no write phase
  task automatic strobe_race(input logic [2:0] a);
    addr = {16'h0, a};
    {sa_n, sb, sc_n, cpu_n, ctl_n, all_n, oe_n} = 7'h20;
    step();
    {cpu_n, ctl_n, all_n} = 3'h7;
    chk("oe after race", {rp_oe, rd_oe}, '1);
    chk("data after race", {rp, rd_d}, mem[a]);
  endtask
  // mid-run reset with a new strap level; stored words must survive it
  task automatic reset_into(input logic m);
    i_sys_rst = 1;
    oe_n = 0;
    mode = m;
    step();
    chk("oe in reset", {rp_oe, rd_oe}, '0);
    i_sys_rst = 0;
    step();
    chk("oe after reset", {rp_oe, rd_oe}, '0);
  endtask
  task automatic end_sim();
    if (n_errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // watchdog well beyond the 33 or so cycles the run needs
  initial begin
    #100000;
    n_errors++;
    end_sim();
  end
  // main sequence
  initial begin
    repeat (4) @(posedge i_clk);
    #1;
    i_sys_rst = 0;
    for (int i = 0; i < 4; i++) wr(3'(i), 36'h5_a5a5_0000 | 36'(i), 4'hf, 1, 0);
    wr(3'h1, 36'hf_ffff_ffff, 4'b1010, 0, 0);
    wr(3'h2, 36'hf_ffff_ffff, 4'h0, 1, 1);
    rd(3'h1, 0);
    rd(3'h3, 0);
    burst_keep(3'h0);
    strobe_race(3'h3);
    reset_into(1'b1);
    burst_keep(3'h1);
    end_sim();
  end
endmodule
`default_nettype wire
